// *** core/sst_params.svh ***
// constants for the synchronous serial transmitter: offsets, fields, resets, rates
// assumes a 32-bit AXI4-Lite register window of four words
`ifndef SST_PARAMS_SVH
`define SST_PARAMS_SVH

// ===========================================================
// register byte offsets
`define SST_OFF_CTRL 8'h00
`define SST_OFF_FILL 8'h04
`define SST_OFF_DATA 8'h08
`define SST_OFF_STAT 8'h0C
`define SST_ADDR_W 8

// ===========================================================
// field positions
`define SST_CTRL_W 10
`define SST_STAT_HOLD_EMPTY 0
`define SST_STAT_FILL_SENT 1
`define SST_STAT_FIFO_FULL 2
`define SST_STAT_LAST_BIT_N 3
`define SST_CMD_FLAG_RESET 0
`define SST_CMD_MASTER_RESET 1

// ===========================================================
// reset values
`define SST_CTRL_RESET 10'h000
`define SST_FILL_RESET 8'h00

// ===========================================================
// clock rate codes and divider terminal counts
`define SST_RATE_1X 2'b00
`define SST_RATE_16X 2'b01
`define SST_RATE_32X 2'b10
`define SST_RATE_64X 2'b11
`define SST_DIV_MAX_1X 6'h00
`define SST_DIV_MAX_16X 6'h0F
`define SST_DIV_MAX_32X 6'h1F
`define SST_DIV_MAX_64X 6'h3F
`define SST_MIN_BITS 4'h5

// ===========================================================
// axi responses
`define SST_RESP_OKAY 2'b00
`define SST_RESP_SLVERR 2'b10

`endif

// *** core/sst_pkg.sv ***
// types shared by the synchronous serial transmitter files
// assumes sst_params.svh supplies the numeric constants
package sst_pkg;

	// ===========================================================
	// control word as held in the control register
	typedef struct packed {
		logic chip_disable;
		logic control_load_strobe_n;
		logic [1:0] word_length_select;
		logic [1:0] operating_mode_select;
		logic [1:0] clock_rate_select;
		logic even_parity_select;
		logic parity_inhibit;
	} sst_ctrl_t;

	// ===========================================================
	// transmitter sequencing
	typedef enum logic [0:0] {
		SST_ST_START = 1'b0,
		SST_ST_RUN = 1'b1
	} sst_state_t;

endpackage

// *** core/sst_fifo2.sv ***
// two-entry buffer with valid/ready on both sides
// assumes one clock and a synchronous active-high flush
module sst_fifo2 (
	// clock and flush
	input wire logic clk,
	input wire logic rst,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [7:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [7:0] out_data
);
	logic [7:0] mem_reg [2];
	logic wr_ptr_reg;
	logic rd_ptr_reg;
	logic [1:0] count_reg;
	logic push;
	logic pop;

	assign in_ready = (count_reg != 2'h2);
	assign out_valid = (count_reg != 2'h0);
	assign out_data = mem_reg[rd_ptr_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			count_reg <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (pop) begin
				rd_ptr_reg <= ~rd_ptr_reg;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 2'h1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 2'h1;
			end
		end
	end
endmodule

// *** core/sst_top.sv ***
// synchronous serial transmitter with AXI4-Lite register access
// assumes shift_clock comes from outside and is slower than aclk / 4
//
// Summary of operation
// [R01] characters of 5 to 8 bits plus optional parity, back to back, no framing
// [R02] fill character goes out whenever no new character is ready
// [R03] one holding register with an empty flag gives a full character time
// [R04] shift load takes holding register when loaded, else the fill register
// [R05] writing the fill register captures the fill character
// [R06] parity inhibit gives none; otherwise even select high even, low odd
// [R07] parity bit follows the last data bit with no gap
// [R08] control latches follow their inputs while the load strobe is low
// [R09] a master reset forces the transmitter into its initial state
// [R10] chip disable low enables parity and control inputs
// [R11] only synchronous mode is built; mode select is stored only
// [R12] rate select 00,01,10,11 gives 1x,16x,32x,64x clocks per bit
// [R13] rising shift clock edge moves the data and times everything
// [R14] flag sets when fill sent for lack of data at last bit centre; at 1x the code judges as the last bit starts
// [R15] holding empty rises on transfer to shifter, falls on load
// [R16] word length 00..11 gives 5..8 bits; upper data bits ignored
// [R17] master reset clears fill flag, sets holding empty, next char is fill
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`include "sst_params.svh"

module sst_top import sst_pkg::*; (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [`SST_ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	// axi write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [`SST_ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	// axi read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// serial link
	input wire logic shift_clock,
	output logic serial_out,
	output logic bit_clock_out,
	output logic last_bit_marker_n,
	// status flags
	output logic holding_empty_flag,
	output logic fill_sent_flag
);
	// ===========================================================
	// declarations
	logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic aw_have_reg, w_have_reg;
	logic [`SST_ADDR_W-1:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg, rdata_next;
	logic wr_fire, wr_done, data_wr, wr_ctrl, wr_fill, wr_stat;
	logic sel_ctrl, sel_fill, sel_data, sel_stat, wr_mapped;
	sst_ctrl_t ctrl_reg, ctrl_eff_reg, ctrl_next;
	logic [7:0] fill_reg;
	logic mr_pulse_reg, rst_int;
	logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [7:0] fifo_out_data;
	logic holding_full_reg, holding_empty_reg;
	logic [7:0] holding_data_reg;
	logic fill_sent_reg, flag_clr;
	logic sck_meta_reg, sck_sync_reg, sck_prev_reg, tick;
	sst_state_t state_reg;
	logic [5:0] div_cnt_reg, div_max;
	logic [3:0] bit_cnt_reg, nd, last_idx;
	logic [8:0] frame_reg, frame_new;
	logic [7:0] char_sel, char_mask;
	logic take_hold_reg, par_en, par_bit, boundary, center, rate_1x;
	logic serial_out_reg, bit_clock_reg, last_bit_n_reg;

	// ===========================================================
	// address decode
	assign sel_ctrl = (awaddr_reg & 8'hFC) == `SST_OFF_CTRL;
	assign sel_fill = (awaddr_reg & 8'hFC) == `SST_OFF_FILL;
	assign sel_data = (awaddr_reg & 8'hFC) == `SST_OFF_DATA;
	assign sel_stat = (awaddr_reg & 8'hFC) == `SST_OFF_STAT;
	assign wr_mapped = sel_ctrl || sel_fill || sel_data || sel_stat;
	assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
	// data write waits for room in the buffer
	assign data_wr = wr_fire && sel_data && wstrb_reg[0];
	assign wr_done = wr_fire && (!data_wr || fifo_in_ready);
	assign wr_ctrl = wr_done && sel_ctrl;
	assign wr_fill = wr_done && sel_fill && wstrb_reg[0];
	assign wr_stat = wr_done && sel_stat && wstrb_reg[0];

	// ===========================================================
	// write address channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b1;
			aw_have_reg <= 1'b0;
			awaddr_reg <= '0;
		end else if (awvalid && awready_reg) begin
			awready_reg <= 1'b0;
			aw_have_reg <= 1'b1;
			awaddr_reg <= awaddr;
		end else if (bvalid_reg && bready) begin
			awready_reg <= 1'b1;
			aw_have_reg <= 1'b0;
		end
	end

	// ===========================================================
	// write data channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_reg <= 1'b1;
			w_have_reg <= 1'b0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
		end else if (wvalid && wready_reg) begin
			wready_reg <= 1'b0;
			w_have_reg <= 1'b1;
			wdata_reg <= wdata;
			wstrb_reg <= wstrb;
		end else if (bvalid_reg && bready) begin
			wready_reg <= 1'b1;
			w_have_reg <= 1'b0;
		end
	end

	// ===========================================================
	// write response channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= `SST_RESP_OKAY;
		end else if (wr_done) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= wr_mapped ? `SST_RESP_OKAY : `SST_RESP_SLVERR;
		end else if (bvalid_reg && bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// ===========================================================
	// read channels
	always_comb begin
		rdata_next = 32'h0000_0000;
		case (araddr & 8'hFC)
			`SST_OFF_CTRL: rdata_next[`SST_CTRL_W-1:0] = ctrl_reg;
			`SST_OFF_FILL: rdata_next[7:0] = fill_reg;
			`SST_OFF_DATA: rdata_next[7:0] = holding_data_reg;
			`SST_OFF_STAT: begin
				rdata_next[`SST_STAT_HOLD_EMPTY] = !holding_full_reg;
				rdata_next[`SST_STAT_FILL_SENT] = fill_sent_reg;
				rdata_next[`SST_STAT_FIFO_FULL] = !fifo_in_ready;
				rdata_next[`SST_STAT_LAST_BIT_N] = last_bit_n_reg;
			end
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= `SST_RESP_OKAY;
		end else if (arvalid && arready_reg) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rdata_reg <= rdata_next;
			rresp_reg <= ((araddr & 8'hF0) == 8'h00) ? `SST_RESP_OKAY : `SST_RESP_SLVERR;
		end else if (rvalid_reg && rready) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
		end
	end

	// ===========================================================
	// control register and its transparent latch copy
	always_comb begin
		ctrl_next = ctrl_reg;
		if (wstrb_reg[0]) begin
			ctrl_next[7:0] = wdata_reg[7:0];
		end
		if (wstrb_reg[1]) begin
			ctrl_next[9:8] = wdata_reg[9:8];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= `SST_CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_reg <= ctrl_next;
		end
	end

	// mode select is kept but only synchronous operation exists   // see [R11]
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_eff_reg <= `SST_CTRL_RESET;
		end else if (!ctrl_reg.control_load_strobe_n && !ctrl_reg.chip_disable) begin
			ctrl_eff_reg <= ctrl_reg; // see [R08] see [R10]
		end
	end

	// ===========================================================
	// master reset command and fill register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mr_pulse_reg <= 1'b0;
		end else begin
			mr_pulse_reg <= wr_stat && wdata_reg[`SST_CMD_MASTER_RESET];
		end
	end
	assign rst_int = !aresetn || mr_pulse_reg; // see [R09]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fill_reg <= `SST_FILL_RESET;
		end else if (wr_fill) begin
			fill_reg <= wdata_reg[7:0]; // see [R05]
		end
	end

	// ===========================================================
	// data buffer ahead of the holding register
	sst_fifo2 u_fifo (
		.clk(aclk),
		.rst(rst_int),
		.in_valid(data_wr),
		.in_ready(fifo_in_ready),
		.in_data(wdata_reg[7:0]),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);
	assign fifo_out_ready = !holding_full_reg;

	// ===========================================================
	// link clock synchroniser and edge detect
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sck_meta_reg <= 1'b0;
			sck_sync_reg <= 1'b0;
			sck_prev_reg <= 1'b0;
		end else begin
			sck_meta_reg <= shift_clock;
			sck_sync_reg <= sck_meta_reg;
			sck_prev_reg <= sck_sync_reg;
		end
	end
	assign tick = sck_sync_reg && !sck_prev_reg; // see [R13]

	// ===========================================================
	// character format
	always_comb begin
		case (ctrl_eff_reg.clock_rate_select) // see [R12]
			`SST_RATE_1X: div_max = `SST_DIV_MAX_1X;
			`SST_RATE_16X: div_max = `SST_DIV_MAX_16X;
			`SST_RATE_32X: div_max = `SST_DIV_MAX_32X;
			`SST_RATE_64X: div_max = `SST_DIV_MAX_64X;
			default: div_max = `SST_DIV_MAX_1X;
		endcase
	end
	assign rate_1x = (div_max == `SST_DIV_MAX_1X);
	assign boundary = tick && (div_cnt_reg == div_max);
	assign center = tick && (rate_1x || div_cnt_reg == (div_max >> 1));

	assign nd = `SST_MIN_BITS + {2'b00, ctrl_eff_reg.word_length_select}; // see [R16]
	assign par_en = !ctrl_eff_reg.parity_inhibit; // see [R06]
	assign last_idx = nd - 4'h1 + {3'b000, par_en};
	assign char_sel = take_hold_reg ? holding_data_reg : fill_reg; // see [R04] see [R02]
	// even: parity equals xor of data; odd: inverted
	assign par_bit = (^(char_sel & char_mask)) ^ !ctrl_eff_reg.even_parity_select; // see [R06]

	genvar gi;
	generate
		for (gi = 0; gi < 9; gi++) begin : g_frame
			if (gi < 8) begin : g_mask
				assign char_mask[gi] = (gi < nd);
			end
			// parity sits right after the last data bit  // see [R07]
			assign frame_new[gi] = (gi < nd) ? ((gi < 8) ? char_sel[gi % 8] : 1'b0) :
				((gi == nd) && par_en && par_bit); // see [R01]
		end
	endgenerate

	// ===========================================================
	// holding register and its empty flag
	always_ff @(posedge aclk) begin
		if (rst_int) begin
			holding_full_reg <= 1'b0; // see [R17]
			holding_empty_reg <= 1'b1;
			holding_data_reg <= 8'h00;
		end else if (fifo_out_valid && fifo_out_ready) begin
			holding_full_reg <= 1'b1; // see [R15]
			holding_empty_reg <= 1'b0;
			holding_data_reg <= fifo_out_data;
		end else if (boundary && state_reg == SST_ST_RUN && bit_cnt_reg == last_idx &&
				take_hold_reg) begin
			holding_full_reg <= 1'b0; // see [R15] see [R03]
			holding_empty_reg <= 1'b1;
		end
	end

	// ===========================================================
	// fill-sent flag; a set in the clearing cycle wins
	assign flag_clr = wr_stat && wdata_reg[`SST_CMD_FLAG_RESET];
	always_ff @(posedge aclk) begin
		if (rst_int) begin
			fill_sent_reg <= 1'b0; // see [R17]
		end else if (boundary && (state_reg == SST_ST_START || bit_cnt_reg == last_idx) &&
				!take_hold_reg) begin
			fill_sent_reg <= 1'b1; // see [R14]
		end else if (flag_clr) begin
			fill_sent_reg <= 1'b0; // see [R14]
		end
	end

	// ===========================================================
	// shifter, divider and line outputs
	always_ff @(posedge aclk) begin
		if (rst_int) begin
			state_reg <= SST_ST_START;
			div_cnt_reg <= 6'h00;
			bit_cnt_reg <= 4'h0;
			frame_reg <= 9'h000;
			take_hold_reg <= 1'b0; // see [R17]
			serial_out_reg <= 1'b1;
			bit_clock_reg <= 1'b0;
			last_bit_n_reg <= 1'b1;
		end else begin
			if (tick) begin
				div_cnt_reg <= (div_cnt_reg == div_max) ? 6'h00 : div_cnt_reg + 6'h01;
			end
			// decide the next source at the centre of the last bit
			// at 1x centre and boundary share a tick: decide as the last bit starts
			if (center && state_reg == SST_ST_RUN &&
					(rate_1x ? (bit_cnt_reg + 4'h1 == last_idx) : (bit_cnt_reg == last_idx))) begin
				take_hold_reg <= holding_full_reg; // see [R14] see [R03]
			end
			if (rate_1x) begin
				bit_clock_reg <= sck_sync_reg;
			end else if (center) begin
				bit_clock_reg <= 1'b0;
			end else if (boundary) begin
				bit_clock_reg <= 1'b1;
			end
			if (boundary) begin
				case (state_reg)
					SST_ST_START, SST_ST_RUN: begin
						if (state_reg == SST_ST_START || bit_cnt_reg == last_idx) begin
							// back to back load, no framing bits   // see [R01]
							state_reg <= SST_ST_RUN;
							frame_reg <= frame_new;
							serial_out_reg <= frame_new[0];
							bit_cnt_reg <= 4'h0;
							last_bit_n_reg <= (last_idx != 4'h0);
						end else begin
							serial_out_reg <= frame_reg[bit_cnt_reg + 4'h1];
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
							last_bit_n_reg <= (bit_cnt_reg + 4'h1 != last_idx);
						end
					end
					default: state_reg <= SST_ST_START;
				endcase
			end
		end
	end

	// ===========================================================
	// outputs
	assign awready = awready_reg;
	assign wready = wready_reg;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign arready = arready_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;
	assign serial_out = serial_out_reg;
	assign bit_clock_out = bit_clock_reg;
	assign last_bit_marker_n = last_bit_n_reg;
	assign holding_empty_flag = holding_empty_reg;
	assign fill_sent_flag = fill_sent_reg;
endmodule

// *** dv/sst_top_asserts.sv ***
// checker for the transmitter's register bus and status flags
// assumes it is bound to sst_top and sees only that module's ports
`include "sst_params.svh"

module sst_top_asserts (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [`SST_ADDR_W-1:0] araddr,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	// link and flags
	input wire logic serial_out,
	input wire logic holding_empty_flag,
	input wire logic fill_sent_flag
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ===========================================================
	// assertions
	AST_RESET_STATE: assert property ($rose(aresetn) |->
		holding_empty_flag && !fill_sent_flag && serial_out)
		else $error("flags or line wrong after reset");
	AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped before taken");
	AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped before taken");
	AST_W_REFUSE: assert property (bvalid |-> !awready && !wready)
		else $error("write accepted while response pending");
	AST_AR_REFUSE: assert property (rvalid |-> !arready)
		else $error("read accepted while data pending");
	AST_R_LATENCY: assert property (arvalid && arready |=> rvalid)
		else $error("read data not one cycle after address");
	AST_RD_SLVERR: assert property (arvalid && arready && araddr[7:4] != 4'h0
		|=> rresp == `SST_RESP_SLVERR && rdata == 32'h0)
		else $error("unmapped read not refused");
	AST_FLAG_STICKY: assert property ($fell(fill_sent_flag) |->
		!$past(awready) || !$past(awready, 2))
		else $error("fill sent flag cleared without a write");

	// ===========================================================
	// covers
	COV_B_STALL: cover property (bvalid && !bready);
	COV_FILL_SENT: cover property ($rose(fill_sent_flag));
	COV_LOADED: cover property ($fell(holding_empty_flag));
endmodule

bind sst_top sst_top_asserts u_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
	.bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
	.serial_out, .holding_empty_flag, .fill_sent_flag);

// *** dv/sst_link_model.sv ***
// link partner: free-running shift clock and a watcher of the serial line
// assumes bit_clock_out falls at the centre of every bit on serial_out
module sst_link_model (
	// link from the transmitter
	input wire logic bit_clock_out,
	input wire logic serial_out,
	input wire logic last_bit_marker_n,
	// clock to the transmitter
	output logic shift_clock
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] cap [$];

	// ===========================================================
	// clock runs free, off the aclk grid, since the stream never pauses
	initial begin
		shift_clock = 1'h0;
		#1.3;
		forever #32 shift_clock = ~shift_clock;
	end

	// ===========================================================
	// bit and end-of-character marker at bit centre
	always @(negedge bit_clock_out) begin
		cap.push_back({~last_bit_marker_n, serial_out});
	end
endmodule

// *** dv/sst_top_tb.sv ***
// self-checking bench: formats, fill insertion, holding flag and bus access
// assumes sst_top, sst_link_model and the bound checker are compiled alongside
`include "sst_params.svh"

module sst_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, shift_clock;
	logic serial_out, bit_clock_out, last_bit_marker_n, holding_empty_flag, fill_sent_flag;
	logic [7:0] awaddr, araddr, fill;
	logic [2:0] awprot, arprot;
	logic [3:0] wstrb;
	logic [31:0] wdata, rdata, d;
	logic [1:0] bresp, rresp, r;
	logic [9:0] ctrl [7] = '{10'h000, 10'h042, 10'h091, 10'h0C2, 10'h0C7, 10'h068, 10'h00D};
	int nd [7] = '{4, 4, 4, 4, 2, 1, 1};
	int n_mismatch = 0;
	int n_compared = 0;
	int seed = 14574;
	logic [7:0] exp_q [$];

	sst_top dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready,
		.wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot,
		.rvalid, .rready, .rdata, .rresp, .shift_clock, .serial_out, .bit_clock_out,
		.last_bit_marker_n, .holding_empty_flag, .fill_sent_flag);
	sst_link_model u_link (.bit_clock_out, .serial_out, .last_bit_marker_n, .shift_clock);

	initial begin
		aclk = 1'h0;
		forever #2 aclk = ~aclk;
	end

	// ===========================================================
	// comparisons and verdict
	task automatic cmp_val(input string what, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic cmp_char(input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH character expected %h seen %h", e, g);
		end
	endtask

	task automatic finish_test();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ===========================================================
	// bus master, ready raised after a random delay
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		bit ad, wd, bd;
		int t;
		ad = 0;
		wd = 0;
		bd = 0;
		t = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		while (!bd && t < 50000) begin
			@(posedge aclk);
			t++;
			if (awvalid && awready) ad = 1;
			if (wvalid && wready) wd = 1;
			if (ad) awvalid <= 1'h0;
			if (wd) wvalid <= 1'h0;
			if (bready && bvalid) begin
				bd = 1;
				cmp_val("bresp", 32'(a[7:4] != 4'h0 ? `SST_RESP_SLVERR : `SST_RESP_OKAY), 32'(bresp));
			end else if (ad && wd && $random(seed) % 2) begin
				bready <= 1'h1;
			end
		end
		bready <= 1'h0;
		if (!bd) n_mismatch++;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
		bit ad, rd;
		int t;
		ad = 0;
		rd = 0;
		t = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		while (!rd && t < 1000) begin
			@(posedge aclk);
			t++;
			if (arvalid && arready) ad = 1;
			if (ad) arvalid <= 1'h0;
			if (rready && rvalid) begin
				rd = 1;
				v = rdata;
				s = rresp;
			end
			else if (ad && $random(seed) % 2) rready <= 1'h1;
		end
		rready <= 1'h0;
		if (!rd) n_mismatch++;
	endtask

	// ===========================================================
	// model of a character on the line: {length, bits lsb first}
	function automatic logic [15:0] frame(input logic [7:0] v, input logic [9:0] c);
		int n;
		logic [11:0] w;
		n = 5 + c[7:6];
		w = 12'(v & (8'hFF >> (8 - n)));
		if (!c[0]) w[n] = c[1] ? ^w : ~^w;
		return {4'(n + (c[0] ? 0 : 1)), w};
	endfunction

	// split captured bits at end markers; first group may be partial
	task automatic chk_stream(input logic [9:0] c);
		logic [11:0] v;
		logic [15:0] g, e;
		int len;
		bit first;
		v = 12'h000;
		len = 0;
		first = 1;
		foreach (u_link.cap[q]) begin
			if (len < 12) v[len] = u_link.cap[q][0];
			len++;
			if (u_link.cap[q][1]) begin
				g = {4'(len), v};
				if (exp_q.size() > 0 && frame(exp_q[0], c) === g) e = frame(exp_q.pop_front(), c);
				else e = frame(fill, c);
				if (!first) cmp_char(e, g);
				first = 0;
				v = 12'h000;
				len = 0;
			end
		end
		cmp_val("data left", 32'h0, exp_q.size());
	endtask

	// ===========================================================
	// main sequence
	initial begin
		int t;
		int n;
		aresetn = 1'h0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata} = 48'h0;
		{awprot, arprot} = 6'h00;
		wstrb = 4'hF;
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		axi_rd(`SST_OFF_CTRL, d, r);
		cmp_val("ctrl reset", 32'h0, d);
		axi_rd(`SST_OFF_FILL, d, r);
		cmp_val("fill reset", 32'h0, d);
		axi_rd(8'h10, d, r);
		cmp_val("unmapped rresp", 32'(`SST_RESP_SLVERR), 32'(r));
		cmp_val("unmapped rdata", 32'h0, d);
		axi_wr(8'h10, 32'h1);
		axi_rd(`SST_OFF_CTRL, d, r);
		cmp_val("unmapped write", 32'h0, d);
		for (int i = 0; i < 7; i++) begin
			fill = 8'($random(seed));
			n = 5 + ctrl[i][7:6] + (ctrl[i][0] ? 0 : 1);
			axi_wr(`SST_OFF_CTRL, 32'(ctrl[i]));
			axi_wr(`SST_OFF_FILL, 32'(fill));
			axi_wr(`SST_OFF_STAT, 32'h2);
			u_link.cap.delete();
			axi_rd(`SST_OFF_STAT, d, r);
			cmp_val("empty after reset", 32'h1, 32'(d[0]));
			axi_rd(`SST_OFF_CTRL, d, r);
			cmp_val("ctrl readback", 32'(ctrl[i]), d);
			for (int j = 0; j < nd[i]; j++) begin
				exp_q.push_back(8'($random(seed)));
				axi_wr(`SST_OFF_DATA, 32'(exp_q[$]));
			end
			// holding loads one cycle after the write is answered
			@(negedge aclk);
			cmp_val("empty while loaded", 32'h0, 32'(holding_empty_flag));
			t = 0;
			while (u_link.cap.size() < (nd[i] + 3) * n && t < 60000) begin
				@(posedge aclk);
				t++;
			end
			if (t >= 60000) n_mismatch++;
			chk_stream(ctrl[i]);
			cmp_val("empty drained", 32'h1, 32'(holding_empty_flag));
			cmp_val("fill sent", 32'h1, 32'(fill_sent_flag));
			// clear just after a character starts, so no fill load sets it again
			@(posedge last_bit_marker_n);
			axi_wr(`SST_OFF_STAT, 32'h1);
			repeat (2) @(posedge aclk);
			cmp_val("fill sent cleared", 32'h0, 32'(fill_sent_flag));
			$display("test %0d done", i);
		end
		finish_test();
	end

	initial begin
		#400000;
		n_mismatch++;
		finish_test();
	end
endmodule
